/* File: logic/lqm_pkg.sv */
// constants for the link quality monitor register bank
// Notes on behaviour
// - the 32-bit variance sum is read through one 16-bit read-only port
// - after freeze, first variance read gives low half, second high half
// - while freeze is set no new variance value is loaded
// - monitor enable is bit 15 of monitor register, read/write, reset 0
// - checks run only with monitor enabled and a valid 100 Mb/s link
// - high threshold at maximum or low threshold at minimum never warns
// - five receiver parameters each checked against low and high limits
// - any violation raises the interrupt when its mask enable is set
// - warning flags sit in bits 9..0 as high/low pairs per parameter
// - monitor register read clears warnings and re-arms the interrupt
// - monitor register bits 14..10 ignore writes and read as zero
// - optional automatic 100 Mb/s link reset from monitor status
// - two consecutive variance reads clear the ready flag and freeze
// - variance loads when 2/4/6/8 ms period ends; writing restarts it
// - thresholds chosen by a 3-bit parameter select and a low/high bit
package lqm_pkg;
    localparam int          REG_W          = 16;
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  ADDR_VAR_CTRL  = 5'h1a;
    localparam logic [4:0]  ADDR_VAR_SUM   = 5'h1b;
    localparam logic [4:0]  ADDR_MON       = 5'h1d;
    localparam logic [4:0]  ADDR_THR       = 5'h1e;
    localparam int          VC_RDY_BIT     = 15;
    localparam int          VC_FRZ_BIT     = 3;
    localparam int          VC_TMR_LSB     = 1;
    localparam int          VC_EN_BIT      = 0;
    localparam int          MON_EN_BIT     = 15;
    localparam int          FLAG_W         = 10;
    localparam int          THR_WR_BIT     = 12;
    localparam int          THR_PSEL_LSB   = 9;
    localparam int          THR_SIDE_BIT   = 8;
    localparam int          NUM_PARAMS     = 5;
    localparam int          PARAM_W        = 8;
    localparam logic [2:0]  PSEL_EQ_COEF   = 3'h0;
    localparam logic [2:0]  PSEL_GAIN      = 3'h1;
    localparam logic [2:0]  PSEL_BLW       = 3'h2;
    localparam logic [2:0]  PSEL_FOFS      = 3'h3;
    localparam logic [2:0]  PSEL_FCTL      = 3'h4;
    localparam logic [7:0]  THR_MAX        = 8'hff;
    localparam logic [7:0]  THR_MIN        = 8'h00;
    localparam logic [7:0]  THR_HI_RST     = THR_MAX;
    localparam logic [7:0]  THR_LO_RST     = THR_MIN;
    localparam logic [15:0] REG_RST        = 16'h0000;
    localparam logic [1:0]  TMR_RST        = 2'h0;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          VAR_UNIT_NS    = 1048576;
    localparam int          VAR_UNIT_CYCLES = VAR_UNIT_NS / CLK_PERIOD_NS;
    localparam int          UNITS_PER_STEP = 2;
    localparam int          UNIT_CNT_W     = 24;
    localparam int          PERIOD_CNT_W   = 4;
endpackage

/* File: logic/lqm_regs.sv */
// variance read port and link quality monitor register bank
`timescale 1ns/1ps
module lqm_regs #(
    parameter int UNIT_CYCLES = lqm_pkg::VAR_UNIT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rdata_valid,
    input  wire logic        link_100_up,
    input  wire logic [31:0] var_sum,
    input  wire logic [39:0] param_values,
    input  wire logic        int_enable,
    input  wire logic        auto_reset_en,
    output logic             lq_interrupt,
    output logic             link_reset,
    output logic             var_compute_en,
    output logic             var_restart
);
    logic [15:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;
    logic        var_en_reg, var_en_next;
    logic [1:0]  tmr_reg, tmr_next;
    logic        frz_reg, frz_next;
    logic        rdy_reg, rdy_next;
    logic        half_reg, half_next;
    logic [31:0] var_hold_reg, var_hold_next;
    logic [23:0] unit_cnt_reg, unit_cnt_next;
    logic [3:0]  per_cnt_reg, per_cnt_next;
    logic        restart_reg, restart_next;
    logic        mon_en_reg, mon_en_next;
    logic [9:0]  flags_reg, flags_next;
    logic        irq_reg, irq_next;
    logic        lreset_reg, lreset_next;
    logic [2:0]  psel_reg, psel_next;
    logic        side_reg, side_next;

    logic        thr_wr;
    logic [7:0]  thr_rdata;
    logic [9:0]  violation;
    logic [9:0]  viol_q;
    logic        rd_var, rd_mon, wr_vc;
    logic [3:0]  per_target;
    logic        elapsed;

    assign rd_var = reg_rd && reg_addr == lqm_pkg::ADDR_VAR_SUM;
    assign rd_mon = reg_rd && reg_addr == lqm_pkg::ADDR_MON;
    assign wr_vc  = reg_wr && reg_addr == lqm_pkg::ADDR_VAR_CTRL;
    assign thr_wr = reg_wr && reg_addr == lqm_pkg::ADDR_THR
                 && reg_wdata[lqm_pkg::THR_WR_BIT];
    // period in units: (select + 1) * 2
    assign per_target = 4'((int'(tmr_reg) + 1) * lqm_pkg::UNITS_PER_STEP);
    assign elapsed = (unit_cnt_reg == 24'(UNIT_CYCLES - 1))
                  && (per_cnt_reg == per_target - 4'h1);

    lqm_thr_cmp u_thr (
        .clock        (clock),
        .rstn         (rstn),
        .thr_wr       (thr_wr),
        .thr_psel     (psel_reg),
        .thr_side     (side_reg),
        .thr_wdata    (reg_wdata[7:0]),
        .param_values (param_values),
        .thr_rdata    (thr_rdata),
        .violation    (violation)
    );

    // monitor flags and interrupt
    always_comb begin
        viol_q = (mon_en_reg && link_100_up) ? violation : 10'h000;
        // set wins over the clear of a read
        flags_next = (rd_mon ? 10'h000 : flags_reg) | viol_q;
        irq_next = (rd_mon ? 1'b0 : irq_reg)
                 | ((|viol_q) && int_enable);
        lreset_next = auto_reset_en && (|viol_q);
    end

    // register access and variance port
    always_comb begin
        rdata_next    = 16'h0000;
        rvalid_next   = reg_rd;
        var_en_next   = var_en_reg;
        tmr_next      = tmr_reg;
        frz_next      = frz_reg;
        rdy_next      = rdy_reg;
        half_next     = half_reg;
        var_hold_next = var_hold_reg;
        unit_cnt_next = unit_cnt_reg;
        per_cnt_next  = per_cnt_reg;
        restart_next  = 1'b0;
        mon_en_next   = mon_en_reg;
        psel_next     = psel_reg;
        side_next     = side_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                lqm_pkg::ADDR_VAR_CTRL: begin
                    rdata_next[lqm_pkg::VC_RDY_BIT] = rdy_reg;
                    rdata_next[lqm_pkg::VC_FRZ_BIT] = frz_reg;
                    rdata_next[lqm_pkg::VC_TMR_LSB +: 2] = tmr_reg;
                    rdata_next[lqm_pkg::VC_EN_BIT] = var_en_reg;
                end
                lqm_pkg::ADDR_VAR_SUM: begin
                    rdata_next = half_reg ? var_hold_reg[31:16]
                                          : var_hold_reg[15:0];
                    half_next = ~half_reg;
                    if (rd_var && half_reg) begin
                        rdy_next = 1'b0;
                        frz_next = 1'b0;
                    end
                end
                lqm_pkg::ADDR_MON: begin
                    rdata_next[lqm_pkg::MON_EN_BIT] = mon_en_reg;
                    rdata_next[lqm_pkg::FLAG_W-1:0] = flags_reg;
                end
                lqm_pkg::ADDR_THR: begin
                    rdata_next[lqm_pkg::THR_PSEL_LSB +: 3] = psel_reg;
                    rdata_next[lqm_pkg::THR_SIDE_BIT] = side_reg;
                    rdata_next[7:0] = thr_rdata;
                end
                default: rdata_next = 16'h0000;
            endcase
        end
        if (reg_wr) begin
            unique case (reg_addr)
                lqm_pkg::ADDR_VAR_CTRL: begin
                    var_en_next = reg_wdata[lqm_pkg::VC_EN_BIT];
                    tmr_next = reg_wdata[lqm_pkg::VC_TMR_LSB +: 2];
                    frz_next = reg_wdata[lqm_pkg::VC_FRZ_BIT];
                    if (reg_wdata[lqm_pkg::VC_FRZ_BIT] && !frz_reg) begin
                        half_next = 1'b0;
                    end
                end
                lqm_pkg::ADDR_MON: begin
                    // bits 14..10 have no storage
                    mon_en_next = reg_wdata[lqm_pkg::MON_EN_BIT];
                end
                lqm_pkg::ADDR_THR: begin
                    psel_next = reg_wdata[lqm_pkg::THR_PSEL_LSB +: 3];
                    side_next = reg_wdata[lqm_pkg::THR_SIDE_BIT];
                end
                default: ;
            endcase
        end
        // computation period timer
        if (!var_en_reg) begin
            unit_cnt_next = 24'h000000;
            per_cnt_next  = 4'h0;
        end else if (wr_vc) begin
            unit_cnt_next = 24'h000000;
            per_cnt_next  = 4'h0;
            restart_next  = 1'b1;
        end else if (elapsed) begin
            unit_cnt_next = 24'h000000;
            per_cnt_next  = 4'h0;
            if (!frz_reg) begin
                var_hold_next = var_sum;
                rdy_next = 1'b1;
                half_next = 1'b0;
            end
        end else if (unit_cnt_reg == 24'(UNIT_CYCLES - 1)) begin
            unit_cnt_next = 24'h000000;
            per_cnt_next  = per_cnt_reg + 4'h1;
        end else begin
            unit_cnt_next = unit_cnt_reg + 24'h000001;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg    <= lqm_pkg::REG_RST;
            rvalid_reg   <= 1'b0;
            var_en_reg   <= 1'b0;
            tmr_reg      <= lqm_pkg::TMR_RST;
            frz_reg      <= 1'b0;
            rdy_reg      <= 1'b0;
            half_reg     <= 1'b0;
            var_hold_reg <= 32'h00000000;
            unit_cnt_reg <= 24'h000000;
            per_cnt_reg  <= 4'h0;
            restart_reg  <= 1'b0;
            mon_en_reg   <= 1'b0;
            flags_reg    <= 10'h000;
            irq_reg      <= 1'b0;
            lreset_reg   <= 1'b0;
            psel_reg     <= lqm_pkg::PSEL_EQ_COEF;
            side_reg     <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            var_en_reg   <= var_en_next;
            tmr_reg      <= tmr_next;
            frz_reg      <= frz_next;
            rdy_reg      <= rdy_next;
            half_reg     <= half_next;
            var_hold_reg <= var_hold_next;
            unit_cnt_reg <= unit_cnt_next;
            per_cnt_reg  <= per_cnt_next;
            restart_reg  <= restart_next;
            mon_en_reg   <= mon_en_next;
            flags_reg    <= flags_next;
            irq_reg      <= irq_next;
            lreset_reg   <= lreset_next;
            psel_reg     <= psel_next;
            side_reg     <= side_next;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign reg_rdata_valid = rvalid_reg;
    assign lq_interrupt    = irq_reg;
    assign link_reset      = lreset_reg;
    assign var_compute_en  = var_en_reg;
    assign var_restart     = restart_reg;
endmodule // lqm_regs

/* File: logic/lqm_thr_cmp.sv */
// threshold store and window comparators for the adapted parameters
`timescale 1ns/1ps
module lqm_thr_cmp (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  thr_wr,
    input  wire logic [2:0]            thr_psel,
    input  wire logic                  thr_side,
    input  wire logic [7:0]            thr_wdata,
    input  wire logic [39:0]           param_values,
    output logic      [7:0]            thr_rdata,
    output logic      [9:0]            violation
);
    logic [7:0] thr_lo_reg  [lqm_pkg::NUM_PARAMS];
    logic [7:0] thr_hi_reg  [lqm_pkg::NUM_PARAMS];
    logic [7:0] thr_lo_next [lqm_pkg::NUM_PARAMS];
    logic [7:0] thr_hi_next [lqm_pkg::NUM_PARAMS];

    always_comb begin
        for (int i = 0; i < lqm_pkg::NUM_PARAMS; i++) begin
            thr_lo_next[i] = thr_lo_reg[i];
            thr_hi_next[i] = thr_hi_reg[i];
            if (thr_wr && thr_psel == i[2:0]) begin
                if (thr_side) begin
                    thr_hi_next[i] = thr_wdata;
                end else begin
                    thr_lo_next[i] = thr_wdata;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < lqm_pkg::NUM_PARAMS; i++) begin
                thr_lo_reg[i] <= lqm_pkg::THR_LO_RST;
                thr_hi_reg[i] <= lqm_pkg::THR_HI_RST;
            end
        end else begin
            for (int i = 0; i < lqm_pkg::NUM_PARAMS; i++) begin
                thr_lo_reg[i] <= thr_lo_next[i];
                thr_hi_reg[i] <= thr_hi_next[i];
            end
        end
    end

    always_comb begin
        thr_rdata = 8'h00;
        for (int i = 0; i < lqm_pkg::NUM_PARAMS; i++) begin
            if (thr_psel == i[2:0]) begin
                thr_rdata = thr_side ? thr_hi_reg[i] : thr_lo_reg[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < lqm_pkg::NUM_PARAMS; g++) begin : g_cmp
            logic [7:0] value;
            assign value = param_values[g*8 +: 8];
            // low flag at even bit, high flag at odd bit
            assign violation[2*g] = (thr_lo_reg[g] != lqm_pkg::THR_MIN)
                                 && (value < thr_lo_reg[g]);
            assign violation[2*g+1] = (thr_hi_reg[g] != lqm_pkg::THR_MAX)
                                   && (value > thr_hi_reg[g]);
        end
    endgenerate
endmodule // lqm_thr_cmp

/* File: verif/link_quality_monitor_regs_tb.sv */
// self-checking bench for the link quality monitor register bank
`timescale 1ns/1ps
module link_quality_monitor_regs_tb;
    logic        clock;
    logic        rstn;
    logic [4:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rdata_valid;
    logic        link_100_up;
    logic [31:0] var_sum;
    logic [39:0] param_values;
    logic        int_enable;
    logic        auto_reset_en;
    logic        lq_interrupt;
    logic        link_reset;
    logic        var_compute_en;
    logic        var_restart;
    int          bad_count;
    int          tests_run;
    logic [15:0] d;
    logic [39:0] p;

    lqm_regs #(.UNIT_CYCLES(8)) dut (
        .clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rdata_valid, .link_100_up, .var_sum, .param_values, .int_enable,
        .auto_reset_en, .lq_interrupt, .link_reset, .var_compute_en,
        .var_restart
    );
    lqm_far_model u_far (.clock, .var_sum, .param_values);

    always #50 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #2000000;
        bad_count++;
        conclude();
    end

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        link_100_up = 1'b1;
        int_enable = 1'b1;
        auto_reset_en = 1'b1;
        bad_count = 0;
        tests_run = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rc(lqm_pkg::ADDR_MON, 16'h0000);
        rc(lqm_pkg::ADDR_VAR_SUM, 16'h0000);
        rc(5'h05, 16'h0000);
        wr(lqm_pkg::ADDR_MON, 16'hffff);
        rc(lqm_pkg::ADDR_MON, 16'h8000);
        for (int i = 0; i < 5; i++) begin
            for (int s = 0; s < 2; s++) begin
                wr(lqm_pkg::ADDR_THR, {4'h0, 3'(i), s[0], 8'h00});
                d = {4'h1, 3'(i), s[0], 8'h80};
                wr(lqm_pkg::ADDR_THR, d);
                rc(lqm_pkg::ADDR_THR, d ^ 16'h1000);
                p = 40'h80_8080_8080;
                p[8*i +: 8] = s[0] ? 8'hc0 : 8'h40;
                u_far.put(p, 32'h0);
                link_100_up <= 1'b0;
                w(3);
                chk({15'h0, lq_interrupt}, 16'h0000);
                @(posedge clock);
                link_100_up <= 1'b1;
                w(3);
                chk({15'h0, lq_interrupt}, 16'h0001);
                chk({15'h0, link_reset}, 16'h0001);
                @(posedge clock);
                link_100_up <= 1'b0;
                d = 16'h8000 | (16'h1 << (2*i+s));
                rc(lqm_pkg::ADDR_MON, d);
                chk({15'h0, lq_interrupt}, 16'h0000);
                rc(lqm_pkg::ADDR_MON, 16'h8000);
                u_far.put(40'h80_8080_8080, 32'h0);
                link_100_up <= 1'b1;
                d = {4'h1, 3'(i), s[0], {8{s[0]}}};
                wr(lqm_pkg::ADDR_THR, d);
            end
        end
        u_far.put(40'hff_00ff_00ff, 32'h0);
        w(3);
        chk({15'h0, lq_interrupt}, 16'h0000);
        u_far.put(40'h00_ff00_ff00, 32'h0);
        w(3);
        rc(lqm_pkg::ADDR_MON, 16'h8000);
        // masked interrupt, no auto reset, flag kept across a read
        @(posedge clock);
        int_enable    <= 1'b0;
        auto_reset_en <= 1'b0;
        wr(lqm_pkg::ADDR_THR, 16'h0000);
        wr(lqm_pkg::ADDR_THR, 16'h1080);
        u_far.put(40'h80_8080_8040, 32'h0);
        w(3);
        chk({15'h0, lq_interrupt}, 16'h0000);
        chk({15'h0, link_reset}, 16'h0000);
        rc(lqm_pkg::ADDR_MON, 16'h8001);
        rc(lqm_pkg::ADDR_MON, 16'h8001);
        wr(lqm_pkg::ADDR_MON, 16'h0000);
        rc(lqm_pkg::ADDR_MON, 16'h0001);
        rc(lqm_pkg::ADDR_MON, 16'h0000);
        u_far.put(40'h80_8080_8080, 32'h1234_abcd);
        wr(lqm_pkg::ADDR_VAR_CTRL, 16'h0001);
        d = 16'h0000;
        for (int n = 0; n < 40 && d[15] !== 1'b1; n++)
            rd(lqm_pkg::ADDR_VAR_CTRL, d);
        chk(d, 16'h8001);
        wr(lqm_pkg::ADDR_VAR_CTRL, 16'h0009);
        u_far.put(40'h80_8080_8080, 32'h5566_7788);
        w(20);
        rc(lqm_pkg::ADDR_VAR_SUM, 16'habcd);
        rc(lqm_pkg::ADDR_VAR_SUM, 16'h1234);
        rc(lqm_pkg::ADDR_VAR_CTRL, 16'h0001);
        // longest period: 8 units of 8 cycles after the restart
        wr(lqm_pkg::ADDR_VAR_CTRL, 16'h0007);
        w(58);
        rc(lqm_pkg::ADDR_VAR_CTRL, 16'h0007);
        w(4);
        rc(lqm_pkg::ADDR_VAR_CTRL, 16'h8007);
        rc(lqm_pkg::ADDR_VAR_SUM, 16'h7788);
        conclude();
    end
endmodule // link_quality_monitor_regs_tb

/* File: verif/lqm_far_model.sv */
// far-side model: adapted parameter values and variance engine result
`timescale 1ns/1ps
module lqm_far_model (
    input  wire logic        clock,
    output logic      [31:0] var_sum,
    output logic      [39:0] param_values
);
    initial begin
        var_sum      = 32'h0000_0000;
        param_values = 40'h80_8080_8080;
    end

    // five unsigned 8-bit parameters, lowest first
    task automatic put(input logic [39:0] p, input logic [31:0] s);
        @(posedge clock);
        param_values <= p;
        var_sum      <= s;
    endtask
endmodule // lqm_far_model

/* File: verif/lqm_regs_props.sv */
// port assertions for the link quality monitor register bank
`timescale 1ns/1ps
module lqm_regs_props #(
    parameter int UNIT_CYCLES = 8
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rdata_valid,
    input wire logic        link_100_up,
    input wire logic        int_enable,
    input wire logic        auto_reset_en,
    input wire logic        lq_interrupt,
    input wire logic        link_reset,
    input wire logic        var_compute_en,
    input wire logic        var_restart
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_resv_zero;
        reg_rd && reg_addr == lqm_pkg::ADDR_MON |=> reg_rdata[14:10] == 5'h00;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("monitor reserved bits not zero");

    property p_mon_en;
        reg_wr && reg_addr == lqm_pkg::ADDR_MON ##1 !reg_wr ##1
        reg_rd && !reg_wr && reg_addr == lqm_pkg::ADDR_MON
        |=> reg_rdata[15] == $past(reg_wdata[15], 3);
    endproperty
    a_mon_en: assert property (p_mon_en)
        else $error("monitor enable readback wrong");

    property p_int_link;
        $rose(lq_interrupt) |-> $past(link_100_up);
    endproperty
    a_int_link: assert property (p_int_link)
        else $error("interrupt raised without link");

    property p_int_mask;
        $rose(lq_interrupt) |-> $past(int_enable);
    endproperty
    a_int_mask: assert property (p_int_mask)
        else $error("interrupt raised while masked");

    property p_int_clear;
        reg_rd && reg_addr == lqm_pkg::ADDR_MON && !link_100_up
        |=> !lq_interrupt;
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("monitor read did not clear interrupt");

    property p_link_reset;
        link_reset |-> $past(auto_reset_en) && $past(link_100_up);
    endproperty
    a_link_reset: assert property (p_link_reset)
        else $error("link reset without cause");

    property p_en_follow;
        reg_wr && reg_addr == lqm_pkg::ADDR_VAR_CTRL
        |=> var_compute_en == $past(reg_wdata[0]);
    endproperty
    a_en_follow: assert property (p_en_follow)
        else $error("variance enable does not follow write");

    property p_restart;
        reg_wr && reg_addr == lqm_pkg::ADDR_VAR_CTRL && var_compute_en
        |=> var_restart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("variance restart missing");

    property p_rd_valid;
        reg_rdata_valid == $past(reg_rd);
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read data valid does not follow read strobe");
endmodule // lqm_regs_props

bind lqm_regs lqm_regs_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
    .clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .link_100_up, .int_enable, .auto_reset_en, .lq_interrupt, .link_reset,
    .var_compute_en, .var_restart, .reg_rdata_valid
);
